// File: hdl/tmz_cfg.svh
// Purpose: Offsets, field positions, reset values and counts of the timer.
// Assumes: Included by the timer top module and the bench top module.
// Notes: Definitions only.
`ifndef TMZ_CFG_SVH
`define TMZ_CFG_SVH
// ==========================================================================
// Register byte offsets
`define TMZ_OFF_COUNT 4'h0
`define TMZ_OFF_OPTION 4'h4
`define TMZ_OFF_INTCTL 4'h8
`define TMZ_OFF_CTRL 4'hC
// ==========================================================================
// Option register fields
`define TMZ_OPT_CS 5
`define TMZ_OPT_SE 4
`define TMZ_OPT_PSA 3
`define TMZ_OPT_RATE_HI 2
`define TMZ_OPT_RATE_LO 0
// ==========================================================================
// Interrupt control fields
`define TMZ_INT_EN 5
`define TMZ_INT_FLAG 2
// ==========================================================================
// Control register fields
`define TMZ_CTRL_SLEEP 0
`define TMZ_CTRL_WDCLR 1
// ==========================================================================
// Reset values and counts
`define TMZ_RST_OPTION 8'hFF
`define TMZ_RST_INTCTL 8'h00
`define TMZ_COUNT_TOP 8'hFF
`define TMZ_INHIBIT_CYCLES 2'h2
`define TMZ_RESP_OKAY 2'h0
`define TMZ_RESP_SLVERR 2'h2
`endif

// File: hdl/tmz_pkg.sv
// Purpose: Types shared by the timer design.
// Assumes: Nothing.
// Notes: Phase codes are one-hot.
package tmz_pkg;
  // ========================================================================
  // Internal phase clocks of one instruction cycle.
  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } tmz_phase_type;
endpackage : tmz_pkg

// File: hdl/tmz_timer.sv
// Purpose: 8-bit timer/counter with shared prescaler, AXI4-Lite registers.
// Assumes: One instruction cycle is four aclk cycles (phases Q1 to Q4).
// Notes: Watchdog counter lives outside; it gets the prescaled tick.
// Functional notes
// - Eight-bit count wraps from FFh to 00h and sets the overflow flag.
// - Source select zero: count once per instruction cycle without prescaler.
// - Writing the count register blocks counting for two instruction cycles.
// - Source select one: count edges of the external count input.
// - Edge select bit chooses rising or falling external edges.
// - Edge select one counts falling edges, zero counts rising edges.
// - Prescaler output is sampled into the count on phases Q2 and Q4.
// - One prescaler, given to timer when assign bit is zero, else watchdog.
// - Timer prescale ratios run from 1:2 to 1:256 via the rate field.
// - Timer counts 1:1 only while prescaler belongs to the watchdog.
// - Prescaler is hidden; a count write clears it when assigned to timer.
// - Watchdog clear also clears the prescaler when assigned to watchdog.
// - Overflow flag sets on every wrap, enabled or not.
// - Interrupt request only when flag and enable are both set.
// - Timer is frozen during sleep.
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "tmz_cfg.svh"
module tmz_timer (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // External count pin and watchdog link
  input wire logic ext_count_input,
  input wire logic wdt_base_tick,
  output logic wdt_prescaled_tick,
  // Interrupt request
  output logic timer_irq
);
  // ========================================================================
  // State
  logic [7:0] timer_count;
  logic [7:0] option_reg;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic sleep_mode;
  logic [7:0] prescaler;
  logic [1:0] inhibit;
  logic pend;
  tmz_pkg::tmz_phase_type phase;
  logic pin_s1, pin_s2, pin_s3;
  logic aw_full, w_full;
  logic [3:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane;

  // Option fields in use.
  logic clock_source_select, source_edge_select, prescaler_assign;
  logic [2:0] prescale_rate;
  assign clock_source_select = option_reg[`TMZ_OPT_CS];
  assign source_edge_select = option_reg[`TMZ_OPT_SE];
  assign prescaler_assign = option_reg[`TMZ_OPT_PSA];
  assign prescale_rate = option_reg[`TMZ_OPT_RATE_HI:`TMZ_OPT_RATE_LO];

  // ========================================================================
  // Register write strobes; a write fires when address and data are held.
  logic do_wr, wr_count, wr_option, wr_intctl, wr_ctrl, wr_hit;
  logic watchdog_clear_instr;
  assign do_wr = aw_full && w_full && !bvalid;
  always_comb begin
    wr_count = 1'b0;
    wr_option = 1'b0;
    wr_intctl = 1'b0;
    wr_ctrl = 1'b0;
    if (aw_addr == `TMZ_OFF_COUNT) begin
      wr_count = do_wr;
    end else if (aw_addr == `TMZ_OFF_OPTION) begin
      wr_option = do_wr;
    end else if (aw_addr == `TMZ_OFF_INTCTL) begin
      wr_intctl = do_wr;
    end else if (aw_addr == `TMZ_OFF_CTRL) begin
      wr_ctrl = do_wr;
    end
  end
  assign wr_hit = wr_count | wr_option | wr_intctl | wr_ctrl;
  assign watchdog_clear_instr = wr_ctrl && w_lane && w_byte[`TMZ_CTRL_WDCLR];

  // ========================================================================
  // Timing: phases, external pin synchroniser and edge choice.
  logic instr_end, ext_edge, tmr_src, pre_in, pre_out, inc;
  logic [7:0] next_prescaler, div_mask;
  assign instr_end = (phase == tmz_pkg::PH_Q4);
  // Selected edge of the synchronised pin.
  assign ext_edge = source_edge_select ? (!pin_s2 && pin_s3)
                                       : (pin_s2 && !pin_s3);
  // Timer event source: selected pin edge, or one per instruction cycle.
  assign tmr_src = clock_source_select ? ext_edge
                                       : (phase == tmz_pkg::PH_Q1);
  // Prescaler input: timer source, or watchdog tick when assigned there.
  assign pre_in = prescaler_assign ? wdt_base_tick : tmr_src;
  // Ratio mask: 2^(n+1) for the timer, 2^n for the watchdog.
  assign div_mask = prescaler_assign
                  ? 8'((8'h01 << prescale_rate) - 8'h01)
                  : 8'((8'h02 << prescale_rate) - 8'h01);
  assign next_prescaler = 8'(prescaler + 8'h01);
  assign pre_out = pre_in && ((next_prescaler & div_mask) == 8'h00);
  // Count advances on Q2 or Q4 from a pending timer event.
  assign inc = pend && !sleep_mode && (inhibit == 2'h0) && !wr_count
             && (phase == tmz_pkg::PH_Q2 || phase == tmz_pkg::PH_Q4);

  // Phase sequencer walking Q1 to Q4.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= tmz_pkg::PH_Q1;
    end else begin
      case (phase)
        tmz_pkg::PH_Q1: phase <= tmz_pkg::PH_Q2;
        tmz_pkg::PH_Q2: phase <= tmz_pkg::PH_Q3;
        tmz_pkg::PH_Q3: phase <= tmz_pkg::PH_Q4;
        default: phase <= tmz_pkg::PH_Q1;
      endcase
    end
  end

  // Two-stage synchroniser plus history stage for edge detection.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
    end else begin
      pin_s1 <= ext_count_input;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Shared prescaler; software cannot see or load it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescaler <= 8'h00;
    end else if (wr_count && !prescaler_assign) begin
      prescaler <= 8'h00;
    end else if (watchdog_clear_instr && prescaler_assign) begin
      prescaler <= 8'h00;
    end else if (pre_in && (prescaler_assign || !sleep_mode)) begin
      prescaler <= next_prescaler;
    end
  end

  // Watchdog gets prescaled ticks when assigned, raw ticks otherwise.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_prescaled_tick <= 1'b0;
    end else begin
      wdt_prescaled_tick <= prescaler_assign ? pre_out
                                             : wdt_base_tick;
    end
  end

  // Pending event waiting for the next Q2 or Q4 sample.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend <= 1'b0;
    end else if (sleep_mode || wr_count) begin
      pend <= 1'b0;
    end else if (!prescaler_assign) begin
      pend <= pre_out || (pend && !inc);
    end else begin
      pend <= tmr_src || (pend && !inc);
    end
  end

  // Two-cycle inhibit after a count write, stepped at instruction ends.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inhibit <= 2'h0;
    end else if (wr_count) begin
      // Outside Q4 one extra step covers the rest of the writing cycle.
      inhibit <= instr_end ? `TMZ_INHIBIT_CYCLES
                           : 2'(`TMZ_INHIBIT_CYCLES + 2'h1);
    end else if (instr_end && inhibit != 2'h0) begin
      inhibit <= 2'(inhibit - 2'h1);
    end
  end

  // Count register; a software write wins over an increment.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_count <= 8'h00;
    end else if (wr_count && w_lane) begin
      timer_count <= w_byte;
    end else if (inc) begin
      timer_count <= 8'(timer_count + 8'h01);
    end
  end

  // Overflow flag: hardware set wins over a software clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag <= 1'b0;
    end else if (inc && timer_count == `TMZ_COUNT_TOP) begin
      overflow_flag <= 1'b1;
    end else if (wr_intctl && w_lane) begin
      overflow_flag <= w_byte[`TMZ_INT_FLAG];
    end
  end

  // Configuration registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      option_reg <= `TMZ_RST_OPTION;
      overflow_irq_enable <= 1'b0;
      sleep_mode <= 1'b0;
    end else begin
      if (wr_option && w_lane) begin
        option_reg <= w_byte;
      end
      if (wr_intctl && w_lane) begin
        overflow_irq_enable <= w_byte[`TMZ_INT_EN];
      end
      if (wr_ctrl && w_lane) begin
        sleep_mode <= w_byte[`TMZ_CTRL_SLEEP];
      end
    end
  end

  // Interrupt request output.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= overflow_flag && overflow_irq_enable;
    end
  end

  // ========================================================================
  // AXI4-Lite write channels, taken in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      aw_addr <= 4'h0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `TMZ_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_full <= 1'b1;
        awready <= 1'b0;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_full <= 1'b1;
        wready <= 1'b0;
        w_byte <= wdata[7:0];
        w_lane <= wstrb[0];
      end
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? `TMZ_RESP_OKAY : `TMZ_RESP_SLVERR;
        aw_full <= 1'b0;
        w_full <= 1'b0;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel with one-cycle answer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `TMZ_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= `TMZ_RESP_OKAY;
      if (araddr == `TMZ_OFF_COUNT) begin
        rdata <= {24'h00_0000, timer_count};
      end else if (araddr == `TMZ_OFF_OPTION) begin
        rdata <= {24'h00_0000, option_reg};
      end else if (araddr == `TMZ_OFF_INTCTL) begin
        rdata <= {26'h000_0000, overflow_irq_enable, 2'h0,
                  overflow_flag, 2'h0};
      end else if (araddr == `TMZ_OFF_CTRL) begin
        rdata <= {31'h0000_0000, sleep_mode};
      end else begin
        rdata <= 32'h0000_0000;
        rresp <= `TMZ_RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ========================================================================
  // Assertions and covers.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_WRAP: assert property (
    inc && timer_count == 8'hFF |=> timer_count == 8'h00 && overflow_flag)
    else $error("Count did not wrap with flag set.");
  AST_FLAG_ALWAYS: assert property (
    inc && timer_count == 8'hFF && !overflow_irq_enable |=> overflow_flag)
    else $error("Flag not set while interrupt disabled.");
  AST_INHIBIT: assert property (
    wr_count |=> !inc [*8])
    else $error("Count advanced during post-write inhibit.");
  AST_INHIBIT_END: assert property (
    wr_count ##1 (!wr_count) [*8]
      |-> ##[1:4] (inhibit == 2'h0 || wr_count))
    else $error("Inhibit outlasted two instruction cycles.");
  AST_SAMPLE_PHASE: assert property (
    inc |-> phase == tmz_pkg::PH_Q2 || phase == tmz_pkg::PH_Q4)
    else $error("Count advanced outside Q2 or Q4.");
  AST_SLEEP: assert property (
    sleep_mode && $past(sleep_mode)
      |-> !inc && ($stable(timer_count) || $past(wr_count)))
    else $error("Count moved during sleep.");
  AST_IRQ: assert property (
    ##1 timer_irq == $past(overflow_flag && overflow_irq_enable))
    else $error("Interrupt not equal to flag and enable.");
  AST_PRE_CLR: assert property (
    wr_count && !prescaler_assign |=> prescaler == 8'h00)
    else $error("Count write left prescaler uncleared.");
  AST_WDT_CLR: assert property (
    watchdog_clear_instr && prescaler_assign && !wr_count
      |=> prescaler == 8'h00)
    else $error("Watchdog clear left prescaler uncleared.");
  AST_DIRECT: assert property (
    prescaler_assign && tmr_src && !sleep_mode && !wr_count |=> pend)
    else $error("Direct event did not become pending.");
  AST_EDGE: assert property (
    clock_source_select && !prescaler_assign && source_edge_select
      && pin_s3 && !pin_s2 |-> pre_in)
    else $error("Falling edge not passed to prescaler.");
  AST_TIMER_SRC: assert property (
    !clock_source_select && !prescaler_assign
      |-> pre_in == (phase == tmz_pkg::PH_Q1))
    else $error("Timer source is not the instruction cycle.");

  COV_WRAP: cover property (inc && timer_count == 8'hFF);
  COV_EXT: cover property (clock_source_select && inc);
  COV_WDT: cover property (prescaler_assign && wdt_prescaled_tick);
  COV_IRQ: cover property ($rose(timer_irq));
endmodule : tmz_timer

// File: sim/tmz_pin_src.sv
// Purpose: Model of the external count source on the count input pin.
// Assumes: Called from the bench; shares the bench clock.
// Notes: The pin idles low and every level is held for eight clocks.
`timescale 1ns/1ps
module tmz_pin_src (
  // Clock
  input wire logic aclk,
  // Count pin
  output logic ext_count_input
);
  // ==========================================================================
  // Pin drive
  // The pin starts low so that the first rise is a real edge.
  initial ext_count_input = 1'b0;

  // Sets a level and holds it long enough for the synchroniser to see it.
  task automatic level(input logic v);
    @(posedge aclk);
    ext_count_input <= v;
    repeat (8) @(posedge aclk);
  endtask : level

  // Sends whole pulses, one rise and one fall each.
  task automatic pulses(input int n);
    repeat (n) begin
      level(1'b1);
      level(1'b0);
    end
  endtask : pulses
endmodule : tmz_pin_src

// File: sim/tmz_timer_tb_top.sv
// Purpose: Self-checking bench of the timer through its register bus.
// Assumes: One instruction cycle is four clocks.
// Notes: Rates are checked as count windows, since phase is free.
`timescale 1ns/1ps
`include "tmz_cfg.svh"
module tmz_timer_tb_top;
  // ==========================================================================
  // Bench signals
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, wdt_base_tick;
  logic wdt_prescaled_tick, timer_irq, ext_count_input;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, v, w;
  logic [1:0] bresp, rresp;
  int checks, n_errors;
  int n_pt = 0;

  tmz_timer uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .ext_count_input(ext_count_input), .wdt_base_tick(wdt_base_tick),
    .wdt_prescaled_tick(wdt_prescaled_tick), .timer_irq(timer_irq));
  tmz_pin_src pin (.aclk(aclk), .ext_count_input(ext_count_input));

  // ==========================================================================
  // Clock and prescaled tick counter
  // The clock runs at 25 MHz.
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Counts prescaled ticks that the watchdog would receive.
  always @(posedge aclk) if (wdt_prescaled_tick === 1'b1) n_pt <= n_pt + 1;

  // ==========================================================================
  // Tasks
  // Waits a number of clock edges.
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // Compares a value with an inclusive window and reports a miss.
  task automatic chk(input logic [31:0] g, lo, hi, input string m);
    checks++;
    if ($isunknown(g) || g < lo || g > hi) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %0h", $time, m, g);
    end
  endtask : chk

  // Runs one write; address and data are offered together.
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [1:0] e = `TMZ_RESP_OKAY);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, e}, {30'h0, e}, "bresp");
  endtask : wr

  // Runs one read and returns the data word.
  task automatic rd(input logic [3:0] a, output logic [31:0] d,
                    input logic [1:0] e = `TMZ_RESP_OKAY);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    chk({30'h0, rresp}, {30'h0, e}, {30'h0, e}, "rresp");
  endtask : rd

  // Sends base ticks from the watchdog clock source, one pulse each.
  task automatic tick(input int n);
    repeat (n) begin
      wdt_base_tick <= 1'b1;
      @(posedge aclk);
      wdt_base_tick <= 1'b0;
      cyc(3);
    end
  endtask : tick

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  // ==========================================================================
  // Watchdog
  // Cuts a hung run short well after the tests should have ended.
  initial begin
    cyc(40000);
    n_errors++;
    finish_test();
  end

  // ==========================================================================
  // Tests
  // Resets the design, then walks through the timer behaviour.
  initial begin
    // Response readies stay high; each answer is taken when it shows.
    {awvalid, wvalid, bready, arvalid, rready, wdt_base_tick} = 6'h0A;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    wstrb = 4'hF;
    aresetn = 1'b0;
    checks = 0;
    n_errors = 0;
    cyc(6);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`TMZ_OFF_OPTION, v);
    chk(v, 32'hFF, 32'hFF, "option reset");
    rd(`TMZ_OFF_INTCTL, v);
    chk(v, 32'h0, 32'h0, "intctl reset");
    rd(`TMZ_OFF_COUNT, v);
    chk(v, 32'h0, 32'h0, "count reset");
    // An unaligned address is refused.
    wr(4'h2, 8'h55, `TMZ_RESP_SLVERR);
    rd(4'h2, v, `TMZ_RESP_SLVERR);
    chk(v, 32'h0, 32'h0, "unmapped data");
    // Timer mode without prescaler, and the hold after a count write.
    wr(`TMZ_OFF_OPTION, 8'h08);
    wr(`TMZ_OFF_COUNT, 8'h40);
    rd(`TMZ_OFF_COUNT, v);
    chk(v, 32'h40, 32'h40, "hold first");
    rd(`TMZ_OFF_COUNT, v);
    chk(v, 32'h40, 32'h40, "hold second");
    cyc(100);
    rd(`TMZ_OFF_COUNT, v);
    chk(v, 32'h57, 32'h5A, "undivided rate");
    // Every timer prescale ratio, each started from a cleared prescaler.
    for (int n = 0; n < 8; n++) begin
      wr(`TMZ_OFF_OPTION, 8'(n));
      wr(`TMZ_OFF_COUNT, 8'h00);
      cyc((36 << n) - 3);
      rd(`TMZ_OFF_COUNT, v);
      chk(v, 32'h3, 32'h4, "prescaled rate");
    end
    // Overflow sets the flag; the request follows the enable.
    wr(`TMZ_OFF_OPTION, 8'h08);
    wr(`TMZ_OFF_INTCTL, 8'h00);
    wr(`TMZ_OFF_COUNT, 8'hFE);
    cyc(30);
    rd(`TMZ_OFF_INTCTL, v);
    chk(v, 32'h04, 32'h04, "flag set masked");
    chk({31'h0, timer_irq}, 32'h0, 32'h0, "irq masked");
    rd(`TMZ_OFF_COUNT, v);
    chk(v, 32'h1, 32'h8, "wrapped count");
    wr(`TMZ_OFF_INTCTL, 8'h24);
    cyc(2);
    chk({31'h0, timer_irq}, 32'h1, 32'h1, "irq raised");
    cyc(150);
    rd(`TMZ_OFF_INTCTL, v);
    chk(v, 32'h24, 32'h24, "flag kept");
    wr(`TMZ_OFF_INTCTL, 8'h20);
    cyc(2);
    chk({31'h0, timer_irq}, 32'h0, 32'h0, "irq dropped");
    // Counter mode on each edge polarity.
    wr(`TMZ_OFF_OPTION, 8'h28);
    wr(`TMZ_OFF_COUNT, 8'h00);
    cyc(10);
    pin.level(1'b1);
    rd(`TMZ_OFF_COUNT, v);
    chk(v, 32'h1, 32'h1, "rising counted");
    wr(`TMZ_OFF_OPTION, 8'h38);
    wr(`TMZ_OFF_COUNT, 8'h10);
    cyc(10);
    pin.level(1'b0);
    rd(`TMZ_OFF_COUNT, v);
    chk(v, 32'h11, 32'h11, "falling counted");
    pin.level(1'b1);
    rd(`TMZ_OFF_COUNT, v);
    chk(v, 32'h11, 32'h11, "rising ignored");
    pin.level(1'b0);
    // Counter mode through the prescaler at 1:4.
    wr(`TMZ_OFF_OPTION, 8'h21);
    wr(`TMZ_OFF_COUNT, 8'h00);
    cyc(10);
    pin.pulses(8);
    rd(`TMZ_OFF_COUNT, v);
    chk(v, 32'h2, 32'h2, "edge prescale");
    // Prescaler moved to the watchdog in the safe order.
    wr(`TMZ_OFF_CTRL, 8'h02);
    wr(`TMZ_OFF_COUNT, 8'h00);
    wr(`TMZ_OFF_OPTION, 8'h29);
    wr(`TMZ_OFF_CTRL, 8'h02);
    wr(`TMZ_OFF_OPTION, 8'h2A);
    w = n_pt;
    tick(3);
    wr(`TMZ_OFF_CTRL, 8'h02);
    tick(3);
    chk(32'(n_pt) - w, 32'h0, 32'h0, "watchdog clear");
    tick(1);
    chk(32'(n_pt) - w, 32'h1, 32'h1, "watchdog ratio");
    // Prescaler moved back to the timer; watchdog ticks pass undivided.
    wr(`TMZ_OFF_CTRL, 8'h02);
    wr(`TMZ_OFF_OPTION, 8'h03);
    w = n_pt;
    tick(4);
    chk(32'(n_pt) - w, 32'h4, 32'h4, "watchdog direct");
    // Sleep freezes the count and waking resumes it.
    wr(`TMZ_OFF_OPTION, 8'h08);
    wr(`TMZ_OFF_COUNT, 8'h00);
    wr(`TMZ_OFF_CTRL, 8'h01);
    cyc(10);
    rd(`TMZ_OFF_COUNT, w);
    cyc(80);
    rd(`TMZ_OFF_COUNT, v);
    chk(v, w, w, "frozen in sleep");
    wr(`TMZ_OFF_CTRL, 8'h00);
    cyc(80);
    rd(`TMZ_OFF_COUNT, v);
    chk(v, w + 32'h13, w + 32'h16, "resumed");
    finish_test();
  end
endmodule : tmz_timer_tb_top
